// File: hw/vic_params.svh
`ifndef VIC_PARAMS_SVH
`define VIC_PARAMS_SVH

// register word offsets
`define VIC_ADDR_CSR 3'h0
`define VIC_ADDR_VBASE 3'h1
`define VIC_ADDR_SLOT_A 3'h2
`define VIC_ADDR_SLOT_B 3'h3
`define VIC_ADDR_SLOT_C 3'h4

// control/status fields
`define VIC_CSR_INT_BIT 15
`define VIC_CSR_NEST_HI 14
`define VIC_CSR_NEST_LO 13
`define VIC_CSR_VNUM_HI 12
`define VIC_CSR_VNUM_LO 6
`define VIC_CSR_GDIS_BIT 5
`define VIC_CSR_CTL_RST 6'h00

// vector base
`define VIC_VBASE_RST_LARGE 14'h0000
`define VIC_VBASE_RST_SMALL 14'h0010

// slot assignment fields, two per register
`define VIC_SLOT_LO_HI 5
`define VIC_SLOT_LO_LO 0
`define VIC_SLOT_HI_HI 13
`define VIC_SLOT_HI_LO 8
`define VIC_CODE_NONE 6'h00
`define VIC_CODE_MIN 6'h0A
`define VIC_CODE_MAX 6'h27

// vector numbers
`define VIC_NUM_VEC 51
`define VIC_VEC_SLOT_BASE 45
`define VIC_VEC_DBG_STEP 5
`define VIC_VEC_ILLEGAL 2
`define VIC_UNMASK_SET 64'h0000_0800_0000_001C

// reset vector low bits: vector 0 or vector 1, two words each
`define VIC_RST_LOW_COLD 7'h00
`define VIC_RST_LOW_WDOG 7'h02

// internal priority ranks
`define VIC_PRIO_NONE 3'h0
`define VIC_PRIO_LP 3'h1
`define VIC_PRIO_L0 3'h2
`define VIC_PRIO_L1 3'h3
`define VIC_PRIO_L2 3'h4
`define VIC_PRIO_L3 3'h5

`endif

// File: hw/vic_pkg.sv
package vic_pkg;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [2:0] addr;
    logic [15:0] wdata;
  } vic_bus_req_t;

  typedef struct packed {
    logic req;
    logic lp;
    logic [1:0] level;
  } vic_core_t;

  typedef logic [2:0] vic_prio_t;

endpackage

// File: hw/vic_slot_match.sv
`timescale 1ns/1ns
`default_nettype none
`include "vic_params.svh"

module vic_slot_match
  import vic_pkg::*;
#(
  parameter int VEC_W = 64
) (
  input wire logic [5:0] code,
  input wire logic [VEC_W-1:0] src_req,
  output logic hit,
  output logic [VEC_W-1:0] claim
);

  logic legal;

  // reserved codes behave as unassigned
  assign legal = (code >= `VIC_CODE_MIN) && (code <= `VIC_CODE_MAX);
  assign claim = legal ? (VEC_W'(1) << code) : '0;
  assign hit = legal && src_req[code];

endmodule // vic_slot_match

`default_nettype wire

// File: hw/vic_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "vic_params.svh"

module vic_top
  import vic_pkg::*;
#(
  parameter bit SMALL_FLASH = 1'b0
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire vic_bus_req_t bus_req,
  output logic [15:0] bus_rdata,
  input wire logic [9:2] core_req,
  input wire logic [39:10] periph_req,
  input wire logic [44:40] swi_req,
  input wire logic wdog_reset,
  input wire logic core_isr_entry,
  output vic_core_t core_irq,
  output logic [20:0] vector_address_bus
);

  localparam logic [13:0] VBASE_RST =
    SMALL_FLASH ? `VIC_VBASE_RST_SMALL : `VIC_VBASE_RST_LARGE;
  localparam int NUM_VEC = `VIC_NUM_VEC;

  logic [5:0] ctl_reg;
  logic [1:0] nest_reg;
  logic [6:0] vnum_reg;
  logic [13:0] vbase_reg;
  logic [5:0] slot_reg [0:5];
  logic [15:0] rdata_next;
  logic rst_hold_reg;
  logic irq_req_reg;
  logic irq_lp_reg;
  logic [1:0] irq_level_reg;
  logic [20:0] vab_reg;
  logic [63:0] raw;
  logic [63:0] gated;
  logic [63:0] claim_all;
  logic [63:0] slot_claim [0:5];
  logic [5:0] slot_hit;
  vic_prio_t best_p;
  logic [5:0] best_v;
  logic [6:0] rst_low;

  // fixed rank of each vector; LP sits below level 0
  function automatic vic_prio_t prio_of(input int v);
    vic_prio_t p;
    p = `VIC_PRIO_NONE;
    if (v >= 2 && v <= 9) begin
      p = `VIC_PRIO_L3;
    end else if (v >= 10 && v <= 40) begin
      p = `VIC_PRIO_L0;
    end else if (v == 41) begin
      p = `VIC_PRIO_L1;
    end else if (v == 42) begin
      p = `VIC_PRIO_L2;
    end else if (v == 43) begin
      p = `VIC_PRIO_L3;
    end else if (v == 44) begin
      p = `VIC_PRIO_LP;
    end else if (v >= 45 && v <= 47) begin
      p = `VIC_PRIO_L1;
    end else if (v >= 48 && v <= 50) begin
      p = `VIC_PRIO_L2;
    end
    return p;
  endfunction

  // level needed to nest over the routine just entered
  function automatic logic [1:0] nest_of(input logic lp, input logic [1:0] lvl);
    logic [1:0] n;
    n = 2'h0;
    if (lp) begin
      n = 2'h0;
    end else if (lvl == 2'h3) begin
      n = 2'h3;
    end else begin
      n = lvl + 2'h1;
    end
    return n;
  endfunction

  // register writes; reserved codes are stored but never match
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ctl_reg <= `VIC_CSR_CTL_RST;
      vbase_reg <= VBASE_RST;
      for (int i = 0; i < 6; i++) begin
        slot_reg[i] <= `VIC_CODE_NONE;
      end
    end else if (bus_req.wr) begin
      unique case (bus_req.addr)
        `VIC_ADDR_CSR: begin
          ctl_reg <= bus_req.wdata[`VIC_CSR_GDIS_BIT:0];
        end
        `VIC_ADDR_VBASE: begin
          vbase_reg <= bus_req.wdata[13:0];
        end
        `VIC_ADDR_SLOT_A: begin
          slot_reg[0] <= bus_req.wdata[`VIC_SLOT_LO_HI:`VIC_SLOT_LO_LO];
          slot_reg[1] <= bus_req.wdata[`VIC_SLOT_HI_HI:`VIC_SLOT_HI_LO];
        end
        `VIC_ADDR_SLOT_B: begin
          slot_reg[2] <= bus_req.wdata[`VIC_SLOT_LO_HI:`VIC_SLOT_LO_LO];
          slot_reg[3] <= bus_req.wdata[`VIC_SLOT_HI_HI:`VIC_SLOT_HI_LO];
        end
        `VIC_ADDR_SLOT_C: begin
          slot_reg[4] <= bus_req.wdata[`VIC_SLOT_LO_HI:`VIC_SLOT_LO_LO];
          slot_reg[5] <= bus_req.wdata[`VIC_SLOT_HI_HI:`VIC_SLOT_HI_LO];
        end
        default: begin
        end
      endcase
    end
  end

  // read mux; unmapped offsets read zero
  always_comb begin
    rdata_next = 16'h0000;
    unique case (bus_req.addr)
      `VIC_ADDR_CSR: begin
        rdata_next = {irq_req_reg, nest_reg, vnum_reg, ctl_reg};
      end
      `VIC_ADDR_VBASE: begin
        rdata_next = {2'h0, vbase_reg};
      end
      `VIC_ADDR_SLOT_A: begin
        rdata_next = {2'h0, slot_reg[1], 2'h0, slot_reg[0]};
      end
      `VIC_ADDR_SLOT_B: begin
        rdata_next = {2'h0, slot_reg[3], 2'h0, slot_reg[2]};
      end
      `VIC_ADDR_SLOT_C: begin
        rdata_next = {2'h0, slot_reg[5], 2'h0, slot_reg[4]};
      end
      default: begin
        rdata_next = 16'h0000;
      end
    endcase
  end

  // read data held until the next read
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      bus_rdata <= 16'h0000;
    end else if (bus_req.rd) begin
      bus_rdata <= rdata_next;
    end
  end

  // sources indexed by their own vector number
  always_comb begin
    raw = '0;
    raw[9:2] = core_req;
    raw[39:10] = periph_req;
    raw[44:40] = swi_req;
  end

  genvar g;
  generate
    for (g = 0; g < 6; g++) begin : gen_slot
      vic_slot_match #(
        .VEC_W(64)
      ) u_slot (
        .code(slot_reg[g]),
        .src_req(raw),
        .hit(slot_hit[g]),
        .claim(slot_claim[g])
      );
    end
  endgenerate

  always_comb begin
    claim_all = '0;
    for (int i = 0; i < 6; i++) begin
      claim_all = claim_all | slot_claim[i];
    end
  end

  // a remapped source leaves its own vector and raises the slot vector
  always_comb begin
    gated = raw & ~claim_all;
    gated[9:5] = gated[9:5] & {ctl_reg[4], ctl_reg[3], ctl_reg[2],
                               ctl_reg[1], ctl_reg[0]};
    gated[50:45] = slot_hit;
    if (ctl_reg[`VIC_CSR_GDIS_BIT]) begin
      gated = gated & `VIC_UNMASK_SET;
    end
  end

  // scan from the top so equal ranks fall to the lower vector
  always_comb begin
    best_p = `VIC_PRIO_NONE;
    best_v = 6'h00;
    for (int v = NUM_VEC - 1; v >= 0; v--) begin
      if (gated[v] && (prio_of(v) >= best_p)) begin
        best_p = prio_of(v);
        best_v = 6'(v);
      end
    end
  end

  // request to core, registered to keep vector and level aligned
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      irq_req_reg <= 1'b0;
      irq_lp_reg <= 1'b0;
      irq_level_reg <= 2'h0;
      vab_reg <= 21'h000000;
    end else begin
      irq_req_reg <= (best_p != `VIC_PRIO_NONE);
      if (best_p != `VIC_PRIO_NONE) begin
        irq_lp_reg <= (best_p == `VIC_PRIO_LP);
        irq_level_reg <= (best_p == `VIC_PRIO_LP) ? 2'h0 : 2'(best_p - `VIC_PRIO_L0);
        vab_reg <= {vbase_reg, best_v, 1'b0};
      end
    end
  end

  // captured only on routine entry so software sees the taken vector
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      nest_reg <= 2'h0;
      vnum_reg <= 7'h00;
    end else if (core_isr_entry && irq_req_reg) begin
      nest_reg <= nest_of(irq_lp_reg, irq_level_reg);
      vnum_reg <= vab_reg[7:1];
    end
  end

  // held until the first edge after release; cleared by that edge
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rst_hold_reg <= 1'b1;
    end else begin
      rst_hold_reg <= 1'b0;
    end
  end

  // the watchdog flag is a live level from the system unit
  assign rst_low = wdog_reset ? `VIC_RST_LOW_WDOG : `VIC_RST_LOW_COLD;
  assign vector_address_bus = rst_hold_reg ? {VBASE_RST, rst_low} : vab_reg;
  assign core_irq = '{req: irq_req_reg && !rst_hold_reg, lp: irq_lp_reg,
                      level: irq_level_reg};

  AST_CSR_INT: assert property (@(posedge sys_clk) disable iff (!nrst)
    bus_req.rd && bus_req.addr == `VIC_ADDR_CSR
      |=> bus_rdata[`VIC_CSR_INT_BIT] == $past(irq_req_reg))
    else $error("status bit 15 does not match request");

  AST_NEST_TOP: assert property (@(posedge sys_clk) disable iff (!nrst)
    core_isr_entry && core_irq.req && !core_irq.lp && core_irq.level == 2'h3
      |=> nest_reg == 2'h3)
    else $error("nest level wrong after level 3 entry");

  AST_VNUM_CAPT: assert property (@(posedge sys_clk) disable iff (!nrst)
    core_isr_entry && core_irq.req
      |=> vnum_reg == $past(vector_address_bus[7:1]))
    else $error("vector number not captured on entry");

  AST_FIELDS_HOLD: assert property (@(posedge sys_clk) disable iff (!nrst)
    !core_isr_entry |=> $stable(vnum_reg) && $stable(nest_reg))
    else $error("status fields changed outside entry");

  AST_GDIS_BLOCK: assert property (@(posedge sys_clk) disable iff (!nrst)
    ctl_reg[`VIC_CSR_GDIS_BIT] && !(|(raw & `VIC_UNMASK_SET))
      |=> !core_irq.req)
    else $error("maskable request passed global disable");

  // base bit 0 lands in address bit 7, so vector compares use bits 6..1
  AST_DBG_STEP: assert property (@(posedge sys_clk) disable iff (!nrst)
    core_irq.req && !$past(ctl_reg[0])
      |-> vector_address_bus[6:1] != 6'(`VIC_VEC_DBG_STEP))
    else $error("disabled step request presented");

  AST_VAB_BASE: assert property (@(posedge sys_clk) disable iff (!nrst)
    core_irq.req |-> vector_address_bus[20:7] == $past(vbase_reg)
      && vector_address_bus[0] == 1'b0)
    else $error("vector address does not carry base");

  AST_RST_VEC: assert property (@(posedge sys_clk) disable iff (!nrst)
    rst_hold_reg |-> vector_address_bus ==
      {VBASE_RST, (wdog_reset ? `VIC_RST_LOW_WDOG : `VIC_RST_LOW_COLD)})
    else $error("reset vector not presented");

  AST_SLOT_IDLE: assert property (@(posedge sys_clk) disable iff (!nrst)
    core_irq.req && $past(slot_reg[0]) == `VIC_CODE_NONE
      |-> vector_address_bus[6:1] != 6'(`VIC_VEC_SLOT_BASE))
    else $error("unassigned slot raised a request");

  AST_PRIO_TOP: assert property (@(posedge sys_clk) disable iff (!nrst)
    raw[`VIC_VEC_ILLEGAL]
      |=> core_irq.req && vector_address_bus[6:1] == 6'(`VIC_VEC_ILLEGAL))
    else $error("highest source not selected");

  AST_NEST_LP: assert property (@(posedge sys_clk) disable iff (!nrst)
    core_isr_entry && core_irq.req && core_irq.lp
      |=> nest_reg == 2'h0)
    else $error("nest level wrong after low priority entry");

  AST_NEST_MID: assert property (@(posedge sys_clk) disable iff (!nrst)
    core_isr_entry && core_irq.req && !core_irq.lp && core_irq.level != 2'h3
      |=> nest_reg == $past(core_irq.level) + 2'h1)
    else $error("nest level not one above entered level");

  AST_CTL_WRITE: assert property (@(posedge sys_clk) disable iff (!nrst)
    bus_req.wr && bus_req.addr == `VIC_ADDR_CSR
      |=> ctl_reg == $past(bus_req.wdata[`VIC_CSR_GDIS_BIT:0]))
    else $error("control bits not written");

  // software polls without a strobe, so the last read must not drift
  AST_RDATA_HOLD: assert property (@(posedge sys_clk) disable iff (!nrst)
    !bus_req.rd |=> $stable(bus_rdata))
    else $error("read data changed without a read");

  AST_SLOT_LVL_ONE: assert property (@(posedge sys_clk) disable iff (!nrst)
    core_irq.req && vector_address_bus[6:1] >= 6'h2D && vector_address_bus[6:1] <= 6'h2F
      |-> !core_irq.lp && core_irq.level == 2'h1)
    else $error("slots one to three not at level 1");

  AST_SLOT_LVL_TWO: assert property (@(posedge sys_clk) disable iff (!nrst)
    core_irq.req && vector_address_bus[6:1] >= 6'h30 && vector_address_bus[6:1] <= 6'h32
      |-> !core_irq.lp && core_irq.level == 2'h2)
    else $error("slots four to six not at level 2");

endmodule // vic_top

`default_nettype wire

// File: verification/vic_core_model.sv
`timescale 1ns/1ns
`default_nettype none

module vic_core_model
  import vic_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire vic_core_t core_irq,
  input wire logic take,
  input wire logic slow,
  output logic core_isr_entry
);
  logic [2:0] wait_cnt;
  logic done;

  // one entry per take window, so a held request is not re-entered each cycle
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      core_isr_entry <= 1'b0;
      wait_cnt <= 3'h0;
      done <= 1'b0;
    end else begin
      core_isr_entry <= 1'b0;
      if (!take) begin
        done <= 1'b0;
        wait_cnt <= 3'h0;
      end else if (core_irq.req && !done) begin
        if (!slow || wait_cnt == 3'h4) begin
          core_isr_entry <= 1'b1;
          done <= 1'b1;
        end else begin
          wait_cnt <= wait_cnt + 3'h1;
        end
      end
    end
  end
endmodule // vic_core_model

`default_nettype wire

// File: verification/testbench.sv
`timescale 1ns/1ns
`default_nettype none

module testbench
  import vic_pkg::*;
;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic wdog_reset = 1'b1;
  logic take = 1'b0;
  logic slow = 1'b0;
  logic rd_seen = 1'b0;
  logic core_isr_entry;
  vic_bus_req_t bus_req = '0;
  logic [15:0] bus_rdata;
  logic [9:2] core_req = '0;
  logic [39:10] periph_req = '0;
  logic [44:40] swi_req = '0;
  vic_core_t core_irq;
  logic [20:0] vector_address_bus;
  logic [15:0] exp_q[$];
  logic [13:0] vb = '0;
  int error_cnt = 0;
  int total_checks = 0;
  int k;
  int src;

  initial forever #20 sys_clk = ~sys_clk;

  vic_top i_vic_top (.sys_clk(sys_clk), .nrst(nrst), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .core_req(core_req), .periph_req(periph_req),
    .swi_req(swi_req), .wdog_reset(wdog_reset), .core_isr_entry(core_isr_entry),
    .core_irq(core_irq), .vector_address_bus(vector_address_bus));

  vic_core_model i_vic_core_model (.sys_clk(sys_clk), .nrst(nrst), .core_irq(core_irq),
    .take(take), .slow(slow), .core_isr_entry(core_isr_entry));

  task automatic fail(input logic [24:0] got, input logic [24:0] exp);
    error_cnt++;
    $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
  endtask

  task automatic cmp_rd(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) fail({9'h000, got}, {9'h000, exp});
  endtask

  task automatic cmp_irq(input logic [24:0] exp);
    logic [24:0] got;
    got = {core_irq.req, core_irq.lp, core_irq.level, vector_address_bus};
    total_checks++;
    if (got !== exp) fail(got, exp);
  endtask

  // only the low-priority software vector carries the lp flag
  function automatic logic [24:0] pres(input logic [5:0] vec, input logic [1:0] lvl);
    return {1'b1, vec == 6'h2C, lvl, vb, vec, 1'b0};
  endfunction

  task automatic report_and_stop;
    $display("checks=%0d errors=%0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    bus_req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge sys_clk);
    bus_req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, input logic [15:0] exp);
    @(posedge sys_clk);
    bus_req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 16'h0000};
    exp_q.push_back(exp);
    @(posedge sys_clk);
    bus_req.rd <= 1'b0;
  endtask

  task automatic go(input logic [9:2] c, input logic [39:10] p, input logic [44:40] s,
    input logic [5:0] vec, input logic [1:0] lvl);
    @(posedge sys_clk);
    core_req <= c;
    periph_req <= p;
    swi_req <= s;
    repeat (2) @(posedge sys_clk);
    #1 cmp_irq(pres(vec, lvl));
  endtask

  // read data lands one edge after the strobe, so compare on the edge after that
  always @(posedge sys_clk) begin
    rd_seen <= bus_req.rd;
    if (rd_seen) cmp_rd(bus_rdata, exp_q.pop_front());
  end

  initial begin
    repeat (5000) @(posedge sys_clk);
    error_cnt++;
    report_and_stop();
  end

  initial begin
    void'($urandom(75350));
    repeat (2) @(posedge sys_clk);
    #1 cmp_irq({4'h0, 14'h0000, 7'h02});
    @(posedge sys_clk);
    wdog_reset <= 1'b0;
    #1 cmp_irq({4'h0, 14'h0000, 7'h00});
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    $display("test reset vector done");
    for (k = 0; k < 6; k++) rd(3'(k), 16'h0000);
    vb = 14'($urandom());
    wr(3'h1, {2'h3, vb});
    rd(3'h1, {2'h0, vb});
    wr(3'h0, 16'hFFDF);
    rd(3'h0, 16'h001F);
    $display("test registers done");
    go(8'h00, 30'h3, 5'h00, 6'h0A, 2'h0);
    go(8'h08, 30'h3, 5'h00, 6'h05, 2'h3);
    go(8'h09, 30'h3, 5'h00, 6'h02, 2'h3);
    wr(3'h0, 16'h001E);
    go(8'h08, 30'h3, 5'h00, 6'h0A, 2'h0);
    wr(3'h0, 16'h003F);
    go(8'h08, 30'h3, 5'h08, 6'h2B, 2'h3);
    go(8'h01, 30'h3, 5'h00, 6'h02, 2'h3);
    wr(3'h0, 16'h001F);
    go(8'h00, 30'h4, 5'h00, 6'h0C, 2'h0);
    $display("test priority done");
    wr(3'h2, 16'h0B0C);
    go(8'h00, 30'h6, 5'h00, 6'h2D, 2'h1);
    wr(3'h4, 16'h2700);
    go(8'h00, 30'h2000_0004, 5'h00, 6'h32, 2'h2);
    for (k = 0; k < 3; k++) begin
      // slot four, high field; codes 11 and 12 stay with slots two and one
      src = 13 + int'($urandom_range(26));
      wr(3'h3, {2'h0, 6'(src), 8'h00});
      go(8'h00, 30'h1 << (src - 10), 5'h00, 6'h30, 2'h2);
    end
    $display("test slots done");
    go(8'h00, 30'h4, 5'h00, 6'h2D, 2'h1);
    @(posedge sys_clk);
    take <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rd(3'h0, {1'b1, 2'h2, vb[0], 6'h2D, 1'b0, 5'h1F});
    @(posedge sys_clk);
    take <= 1'b0;
    go(8'h01, 30'h4, 5'h00, 6'h02, 2'h3);
    rd(3'h0, {1'b1, 2'h2, vb[0], 6'h2D, 1'b0, 5'h1F});
    @(posedge sys_clk);
    slow <= 1'b1;
    take <= 1'b1;
    repeat (10) @(posedge sys_clk);
    rd(3'h0, {1'b1, 2'h3, vb[0], 6'h02, 1'b0, 5'h1F});
    go(8'h00, 30'h0, 5'h10, 6'h2C, 2'h0);
    @(posedge sys_clk);
    take <= 1'b0;
    slow <= 1'b0;
    @(posedge sys_clk);
    take <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rd(3'h0, {1'b1, 2'h0, vb[0], 6'h2C, 1'b0, 5'h1F});
    $display("test service entry done");
    @(posedge sys_clk);
    nrst <= 1'b0;
    take <= 1'b0;
    core_req <= '0;
    periph_req <= '0;
    swi_req <= '0;
    #1 cmp_irq({4'h0, 14'h0000, 7'h00});
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    for (k = 0; k < 3; k++) rd(3'(k), 16'h0000);
    $display("test second reset done");
    repeat (3) @(posedge sys_clk);
    report_and_stop();
  end
endmodule // testbench

`default_nettype wire
